// file: include/bma_pkg.sv
// Purpose: constants and types for boot mode decode and address map
// Assumes: one clock, synchronous active-low reset
// Notes: shared by mode decoder, address unit and top
// Notes on behaviour
// RL1: select pins pick ROMless or single-chip mode
// RL2: other pin codes are prohibited, undefined behaviour
// RL3: supply high plus select 01x means flash programming
// RL4: single-chip 0 boots internal ROM, pins port
// RL5: pins join bus after pin-control writes
// RL6: single-chip 1 boots external, ROM at 100000H
// RL7: ROMless boots external, internal ROM blocked
// RL8: ROMless 0 bus 16-bit, ROMless 1 8-bit
// RL9: pin-control and bus-size resets depend on mode
// RL10: board keeps select pins fixed while running
// RL11: 4 GB data space, 64 MB program space
// RL12: address bits 31 to 28 ignored
// RL13: program counter upper six bits stay zero
// RL14: program addresses wrap at 03FFFFFFH
// RL15: data addresses truncated to 32 bits
// RL16: no branch targets into peripheral image
// RL17: mode latched at reset release, held
package bma_pkg;

  localparam int PC_BITS = 26;
  localparam int PHYS_BITS = 28;

  typedef enum logic [2:0] {
    MODE_ROMLESS0,
    MODE_ROMLESS1,
    MODE_SINGLE0,
    MODE_SINGLE1,
    MODE_FLASH,
    MODE_PROHIBITED
  } bma_mode_t;

  // select pin codes, bit2..bit0
  localparam logic [2:0] SEL_ROMLESS0 = 3'h0;
  localparam logic [2:0] SEL_ROMLESS1 = 3'h1;
  localparam logic [2:0] SEL_SINGLE0 = 3'h2;
  localparam logic [2:0] SEL_SINGLE1 = 3'h3;
  localparam logic [1:0] SEL_FLASH_HI = 2'h1;

  // register byte offsets
  localparam logic [31:0] OFS_DATA_HIGH = 32'h0000_0000;
  localparam logic [31:0] OFS_DATA_LOW = 32'h0000_0004;
  localparam logic [31:0] OFS_CHIP_SEL = 32'h0000_0008;
  localparam logic [31:0] OFS_STROBE = 32'h0000_000C;
  localparam logic [31:0] OFS_MISC = 32'h0000_0010;
  localparam logic [31:0] OFS_BUS_WIDTH = 32'h0000_0014;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0018;

  // status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ROM_BLOCKED = 4;
  localparam int ST_INT_BOOT = 5;
  localparam int ST_BUS16 = 6;
  localparam int ST_PROHIBITED = 7;
  localparam int ST_FLASH = 8;

  localparam logic [15:0] RST_BUSW_WIDE = 16'h5555;
  localparam logic [15:0] RST_BUSW_NARROW = 16'h0000;

  localparam logic [PHYS_BITS-1:0] ROM_BASE_LOW = 28'h000_0000;
  localparam logic [PHYS_BITS-1:0] ROM_BASE_HIGH = 28'h010_0000;
  localparam logic [PHYS_BITS-1:0] ROM_AREA_SIZE = 28'h010_0000;
  localparam logic [PC_BITS-1:0] IO_IMAGE_BASE = 26'h3FF_F000;

  typedef struct packed {
    logic [7:0] pinctlDataHigh;
    logic [15:0] pinctlDataLow;
    logic [7:0] pinctlChipSelect;
    logic [7:0] pinctlStrobe;
    logic [7:0] pinctlMisc;
  } bma_pinctl_t;

  localparam bma_pinctl_t PINCTL_PORT = '{8'h00, 16'h0000, 8'h00, 8'h00, 8'h00};
  localparam bma_pinctl_t PINCTL_CTRL = '{8'hFF, 16'hFFFF, 8'hFF, 8'h53, 8'h0F};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } bma_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bma_apb_rsp_t;

  typedef struct packed {
    bma_mode_t mode;
    logic internalBoot;
    logic romBlocked;
    logic busWidth16;
    logic [PHYS_BITS-1:0] romBase;
  } bma_mode_info_t;

  typedef struct packed {
    logic [31:0] pcTarget;
    logic [31:0] dataAddr;
    logic [PHYS_BITS-1:0] physAddr;
    logic romHit;
    logic romBlocked;
    logic ioFetchFault;
  } bma_addr_res_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    bma_mode_t mode;
  } bma_dec_st_t;

  typedef struct packed {
    bma_addr_res_t res;
    logic valid;
  } bma_addr_st_t;

  typedef struct packed {
    bma_apb_rsp_t rsp;
    bma_pinctl_t pin;
    logic [15:0] busWidthConfig;
    bma_mode_info_t info;
    logic prohibited;
    logic flashProg;
  } bma_top_st_t;

endpackage

// file: rtl/bma_mode_decode.sv
// Purpose: synchronise select pins and latch the operating mode
// Assumes: pins are static while running
// Notes: mode follows the pins only while reset is low
`timescale 1ns/1ns
module bma_mode_decode import bma_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic opSelectBit0,
  input wire logic opSelectBit1,
  input wire logic opSelectBit2,
  input wire logic vppHigh,
  output bma_mode_t mode
);

  bma_dec_st_t st_ff;
  bma_dec_st_t nxt_st;

  function automatic bma_mode_t decodeSel(input logic [3:0] s);
    bma_mode_t m;
    m = MODE_PROHIBITED;
    if (s[3]) begin
      if (s[2:1] == SEL_FLASH_HI) begin
        m = MODE_FLASH; // see RL3
      end
    end else begin
      case (s[2:0]) // see RL1
        SEL_ROMLESS0: m = MODE_ROMLESS0;
        SEL_ROMLESS1: m = MODE_ROMLESS1;
        SEL_SINGLE0: m = MODE_SINGLE0;
        SEL_SINGLE1: m = MODE_SINGLE1;
        default: m = MODE_PROHIBITED; // see RL2
      endcase
    end
    return m;
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = {vppHigh, opSelectBit2, opSelectBit1, opSelectBit0};
    nxt_st.sync2 = st_ff.sync1;
    if (!nrst) begin
      nxt_st.mode = decodeSel(st_ff.sync2); // see RL17
    end
  end

  always_ff @(posedge clk_sys) begin
    st_ff <= nxt_st;
  end

  assign mode = st_ff.mode;

  ////////////////////////////////////////////////////////////////////////////
  default clocking dcb @(posedge clk_sys); endclocking

  dec_single1_a: assert property ( // see RL1
    !nrst && st_ff.sync2 == {1'b0, SEL_SINGLE1} |=> st_ff.mode == MODE_SINGLE1)
    else $error("single-chip 1 code not decoded");
  dec_flash_a: assert property ( // see RL3
    !nrst && st_ff.sync2[3] && st_ff.sync2[2:1] == SEL_FLASH_HI |=> st_ff.mode == MODE_FLASH)
    else $error("flash programming code not decoded");
  dec_prohib_a: assert property ( // see RL2
    !nrst && st_ff.sync2[3] && st_ff.sync2[2:1] != SEL_FLASH_HI
    |=> st_ff.mode == MODE_PROHIBITED)
    else $error("prohibited code not flagged");
  mode_hold_a: assert property ( // see RL17
    nrst |=> $stable(st_ff.mode))
    else $error("mode changed outside reset");

endmodule // bma_mode_decode

// file: rtl/bma_addr_unit.sv
// Purpose: program and data address wrap, image fold, ROM window check
// Assumes: calcValid is a one-cycle request on clk_sys
// Notes: results appear one cycle after the request
`timescale 1ns/1ns
module bma_addr_unit import bma_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input bma_mode_t mode,
  input wire logic calcValid,
  input wire logic [31:0] pcBase,
  input wire logic [31:0] branchDisp,
  input wire logic [31:0] dataBase,
  input wire logic [31:0] dataDisp,
  output bma_addr_res_t addrRes,
  output logic addrValid
);

  bma_addr_st_t st_ff;
  bma_addr_st_t nxt_st;
  logic [PC_BITS-1:0] pcSum;
  logic [31:0] dSum;
  logic [PHYS_BITS-1:0] romBase;
  logic [PHYS_BITS-1:0] dataOff;
  logic [PHYS_BITS-1:0] pcOff;
  logic romOk;
  logic romless;

  always_comb begin
    pcSum = pcBase[PC_BITS-1:0] + branchDisp[PC_BITS-1:0]; // see RL13
    dSum = dataBase + dataDisp; // see RL15
    romBase = (mode == MODE_SINGLE1) ? ROM_BASE_HIGH : ROM_BASE_LOW; // see RL6
    dataOff = dSum[PHYS_BITS-1:0] - romBase;
    pcOff = {2'b00, pcSum} - romBase;
    romOk = (mode == MODE_SINGLE0) || (mode == MODE_SINGLE1) || (mode == MODE_FLASH);
    romless = (mode == MODE_ROMLESS0) || (mode == MODE_ROMLESS1);
    nxt_st = st_ff;
    nxt_st.valid = 1'b0;
    if (!nrst) begin
      nxt_st = '0;
    end else if (calcValid) begin
      nxt_st.valid = 1'b1;
      nxt_st.res.pcTarget = {{(32-PC_BITS){1'b0}}, pcSum}; // see RL14
      nxt_st.res.dataAddr = dSum; // see RL11
      nxt_st.res.physAddr = dSum[PHYS_BITS-1:0]; // see RL12
      nxt_st.res.romHit = romOk && (dataOff < ROM_AREA_SIZE);
      nxt_st.res.romBlocked = romless &&
        ((dSum[PHYS_BITS-1:0] < ROM_AREA_SIZE) || ({2'b00, pcSum} < ROM_AREA_SIZE) ||
         (pcOff < ROM_AREA_SIZE)); // see RL7
      nxt_st.res.ioFetchFault = (pcSum >= IO_IMAGE_BASE); // see RL16
    end
  end

  always_ff @(posedge clk_sys) begin
    st_ff <= nxt_st;
  end

  assign addrRes = st_ff.res;
  assign addrValid = st_ff.valid;

  ////////////////////////////////////////////////////////////////////////////
  default clocking acb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  pc_wrap_a: assert property ( // see RL13
    calcValid |=> addrValid && addrRes.pcTarget[31:PC_BITS] == '0 &&
    addrRes.pcTarget[PC_BITS-1:0] == $past(pcSum))
    else $error("program target not wrapped to 26 bits");
  data_image_a: assert property ( // see RL12
    addrValid |-> addrRes.physAddr == addrRes.dataAddr[PHYS_BITS-1:0])
    else $error("physical address not folded");
  rom_block_a: assert property ( // see RL7
    calcValid && romless |=> !addrRes.romHit &&
      (addrRes.romBlocked || addrRes.physAddr >= ROM_AREA_SIZE))
    else $error("internal ROM reached in ROMless mode");
  data_wrap_a: assert property ( // see RL15
    calcValid |=> addrRes.dataAddr == $past(dSum))
    else $error("data address not truncated");

endmodule // bma_addr_unit

// file: rtl/bma_boot_ctrl.sv
// Purpose: boot mode control, pin-control and bus-size registers over APB
// Assumes: select pins static; reset held at least four clk_sys edges
// Notes: answer comes in the first access cycle, no extra wait
`timescale 1ns/1ns
module bma_boot_ctrl import bma_pkg::*; (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic opSelectBit0,
  input wire logic opSelectBit1,
  input wire logic opSelectBit2,
  input wire logic vppHigh,
  input bma_apb_req_t apbReq,
  output bma_apb_rsp_t apbRsp,
  output bma_pinctl_t pinctl,
  output logic [15:0] busWidthConfig,
  output bma_mode_info_t modeInfo,
  output logic modeProhibited,
  output logic flashProg,
  input wire logic calcValid,
  input wire logic [31:0] pcBase,
  input wire logic [31:0] branchDisp,
  input wire logic [31:0] dataBase,
  input wire logic [31:0] dataDisp,
  output bma_addr_res_t addrRes,
  output logic addrValid
);

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  bma_mode_t decMode;
  bma_mode_t curMode;

  bma_mode_decode u_decode (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .opSelectBit0(opSelectBit0),
    .opSelectBit1(opSelectBit1),
    .opSelectBit2(opSelectBit2),
    .vppHigh(vppHigh),
    .mode(decMode)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address unit

  bma_addr_unit u_addr (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .mode(curMode),
    .calcValid(calcValid),
    .pcBase(pcBase),
    .branchDisp(branchDisp),
    .dataBase(dataBase),
    .dataDisp(dataDisp),
    .addrRes(addrRes),
    .addrValid(addrValid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  bma_top_st_t st_ff;
  bma_top_st_t nxt_st;
  bma_mode_info_t infoNow;
  logic setupPhase;
  logic accessPhase;
  logic wrEn;
  logic rdHit;
  logic [31:0] rdData;
  logic [7:0] wrByte;

  assign curMode = st_ff.info.mode;
  assign wrByte = apbReq.pwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // mode information derived from the latched mode

  always_comb begin
    infoNow.mode = decMode;
    infoNow.internalBoot = (decMode == MODE_SINGLE0) || (decMode == MODE_FLASH); // see RL4
    infoNow.romBlocked = (decMode == MODE_ROMLESS0) ||
      (decMode == MODE_ROMLESS1); // see RL7
    infoNow.busWidth16 = (decMode != MODE_ROMLESS1); // see RL8
    if (decMode == MODE_SINGLE1) begin
      infoNow.romBase = ROM_BASE_HIGH; // see RL6
    end else begin
      infoNow.romBase = ROM_BASE_LOW; // see RL1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb phase decode

  always_comb begin
    setupPhase = apbReq.psel && !apbReq.penable;
    accessPhase = apbReq.psel && apbReq.penable && st_ff.rsp.pready;
    wrEn = accessPhase && apbReq.pwrite && rdHit && (apbReq.paddr != OFS_STATUS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and address decode

  always_comb begin
    rdHit = 1'b1;
    rdData = '0;
    case (apbReq.paddr)
      OFS_DATA_HIGH: begin
        rdData[7:0] = st_ff.pin.pinctlDataHigh;
      end
      OFS_DATA_LOW: begin
        rdData[15:0] = st_ff.pin.pinctlDataLow;
      end
      OFS_CHIP_SEL: begin
        rdData[7:0] = st_ff.pin.pinctlChipSelect;
      end
      OFS_STROBE: begin
        rdData[7:0] = st_ff.pin.pinctlStrobe;
      end
      OFS_MISC: begin
        rdData[7:0] = st_ff.pin.pinctlMisc;
      end
      OFS_BUS_WIDTH: begin
        rdData[15:0] = st_ff.busWidthConfig;
      end
      OFS_STATUS: begin
        rdData[ST_MODE_LSB +: 3] = st_ff.info.mode;
        rdData[ST_ROM_BLOCKED] = st_ff.info.romBlocked;
        rdData[ST_INT_BOOT] = st_ff.info.internalBoot;
        rdData[ST_BUS16] = st_ff.info.busWidth16;
        rdData[ST_PROHIBITED] = st_ff.prohibited;
        rdData[ST_FLASH] = st_ff.flashProg;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.pready = 1'b0;
    nxt_st.rsp.pslverr = 1'b0;
    if (!nrst) begin
      nxt_st.rsp = '0;
      nxt_st.info = infoNow; // see RL17
      nxt_st.prohibited = (decMode == MODE_PROHIBITED); // see RL2
      nxt_st.flashProg = (decMode == MODE_FLASH); // see RL3
      if (decMode == MODE_SINGLE0) begin
        nxt_st.pin = PINCTL_PORT; // see RL4
      end else begin
        nxt_st.pin = PINCTL_CTRL; // see RL9
      end
      if (decMode == MODE_ROMLESS1) begin
        nxt_st.busWidthConfig = RST_BUSW_NARROW; // see RL9
      end else begin
        nxt_st.busWidthConfig = RST_BUSW_WIDE;
      end
    end else begin
      if (setupPhase) begin
        nxt_st.rsp.pready = 1'b1;
        nxt_st.rsp.pslverr = !rdHit;
        nxt_st.rsp.prdata = rdData;
      end
      if (wrEn) begin
        case (apbReq.paddr) // see RL5
          OFS_DATA_HIGH: begin
            nxt_st.pin.pinctlDataHigh = wrByte;
          end
          OFS_DATA_LOW: begin
            nxt_st.pin.pinctlDataLow = apbReq.pwdata[15:0];
          end
          OFS_CHIP_SEL: begin
            nxt_st.pin.pinctlChipSelect = wrByte;
          end
          OFS_STROBE: begin
            nxt_st.pin.pinctlStrobe = wrByte;
          end
          OFS_MISC: begin
            nxt_st.pin.pinctlMisc = wrByte;
          end
          OFS_BUS_WIDTH: begin
            nxt_st.busWidthConfig = apbReq.pwdata[15:0];
          end
          default: begin
            nxt_st.busWidthConfig = st_ff.busWidthConfig;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign apbRsp = st_ff.rsp;
  assign pinctl = st_ff.pin;
  assign busWidthConfig = st_ff.busWidthConfig;
  assign modeInfo = st_ff.info;
  assign modeProhibited = st_ff.prohibited;
  assign flashProg = st_ff.flashProg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking tcb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence apbSetup;
    apbReq.psel && !apbReq.penable;
  endsequence

  sequence apbAnswer;
    apbRsp.pready ##1 !apbRsp.pready;
  endsequence

  apb_answer_a: assert property (
    apbSetup |=> apbAnswer)
    else $error("apb answer not one access cycle");
  apb_unmapped_a: assert property (
    apbSetup and !rdHit |=> apbRsp.pslverr && apbRsp.prdata == '0)
    else $error("unmapped address not refused");
  s0_port_mode_a: assert property ( // see RL4
    $rose(nrst) && st_ff.info.mode == MODE_SINGLE0 |-> pinctl == PINCTL_PORT)
    else $error("single-chip 0 pins not in port mode");
  ctl_mode_rst_a: assert property ( // see RL9
    $rose(nrst) && st_ff.info.mode != MODE_SINGLE0 |-> pinctl == PINCTL_CTRL)
    else $error("pin-control reset value wrong");
  busw_rst_a: assert property ( // see RL8
    $rose(nrst) |-> busWidthConfig ==
      ((st_ff.info.mode == MODE_ROMLESS1) ? RST_BUSW_NARROW : RST_BUSW_WIDE))
    else $error("bus-size reset value wrong");
  pin_write_a: assert property ( // see RL5
    wrEn && apbReq.paddr == OFS_DATA_HIGH |=> pinctl.pinctlDataHigh == $past(wrByte))
    else $error("pin-control write lost");
  pin_hold_a: assert property ( // see RL5
    !wrEn |=> $stable(pinctl))
    else $error("pin-control changed without write");
  s1_rom_base_a: assert property ( // see RL6
    modeInfo.mode == MODE_SINGLE1 |-> modeInfo.romBase == ROM_BASE_HIGH &&
      !modeInfo.internalBoot)
    else $error("single-chip 1 ROM not relocated");

  ////////////////////////////////////////////////////////////////////////////
  // register and mode information checks

  sequence apbWrite;
    apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
  endsequence

  pin_low_wr_a: assert property ( // see RL5
    apbWrite and apbReq.paddr == OFS_DATA_LOW
    |=> {16'h0000, pinctl.pinctlDataLow} == ($past(apbReq.pwdata) & 32'h0000_FFFF))
    else $error("pin-control low half write lost");
  pin_cs_wr_a: assert property ( // see RL5
    apbWrite and apbReq.paddr == OFS_CHIP_SEL |=> pinctl.pinctlChipSelect == $past(wrByte))
    else $error("chip-select pin-control write lost");
  pin_strb_wr_a: assert property ( // see RL5
    apbWrite and apbReq.paddr == OFS_STROBE |=> pinctl.pinctlStrobe == $past(wrByte))
    else $error("strobe pin-control write lost");
  pin_misc_wr_a: assert property ( // see RL5
    apbWrite and apbReq.paddr == OFS_MISC |=> pinctl.pinctlMisc == $past(wrByte))
    else $error("misc pin-control write lost");
  busw_write_a: assert property ( // see RL9
    apbWrite and apbReq.paddr == OFS_BUS_WIDTH
    |=> {16'h0000, busWidthConfig} == ($past(apbReq.pwdata) & 32'h0000_FFFF))
    else $error("bus-size write lost");
  busw_hold_a: assert property ( // see RL9
    !wrEn |=> $stable(busWidthConfig))
    else $error("bus-size changed without write");
  status_ro_a: assert property ( // see RL17
    apbWrite and apbReq.paddr == OFS_STATUS |=> $stable(pinctl) && $stable(busWidthConfig))
    else $error("status write reached a register");
  unmapped_wr_a: assert property (
    apbWrite and !rdHit |=> $stable(pinctl) && $stable(busWidthConfig))
    else $error("unmapped write reached a register");
  status_rd_a: assert property ( // see RL17
    apbSetup and apbReq.paddr == OFS_STATUS
    |=> apbRsp.prdata[ST_MODE_LSB +: 3] == modeInfo.mode &&
    apbRsp.prdata[ST_PROHIBITED] == modeProhibited && apbRsp.prdata[ST_FLASH] == flashProg)
    else $error("status read does not show the mode");
  rd_high_a: assert property ( // see RL5
    apbSetup and apbReq.paddr == OFS_DATA_HIGH
    |=> apbRsp.prdata == {24'h00_0000, pinctl.pinctlDataHigh})
    else $error("pin-control readback wrong");
  info_hold_a: assert property ( // see RL17
    nrst |=> $stable(modeInfo) && $stable(modeProhibited) && $stable(flashProg))
    else $error("mode information changed outside reset");
  s0_boot_a: assert property ( // see RL4
    modeInfo.mode == MODE_SINGLE0 |-> modeInfo.internalBoot && !modeInfo.romBlocked &&
      modeInfo.romBase == ROM_BASE_LOW)
    else $error("single-chip 0 not booting internal ROM");
  romless_a: assert property ( // see RL7
    modeInfo.romBlocked |-> !modeInfo.internalBoot &&
      modeInfo.mode inside {MODE_ROMLESS0, MODE_ROMLESS1})
    else $error("ROM blocked outside ROMless mode");
  bus_width_a: assert property ( // see RL8
    modeInfo.mode inside {MODE_ROMLESS0, MODE_ROMLESS1} |->
      modeInfo.busWidth16 == (modeInfo.mode == MODE_ROMLESS0))
    else $error("ROMless bus width wrong");
  flash_flag_a: assert property ( // see RL3
    flashProg |-> modeInfo.mode == MODE_FLASH && modeInfo.internalBoot)
    else $error("flash flag without flash mode");
  prohib_flag_a: assert property ( // see RL2
    modeProhibited |-> modeInfo.mode == MODE_PROHIBITED)
    else $error("prohibited flag without prohibited mode");

endmodule // bma_boot_ctrl

// file: tb/bma_strap_model.sv
// Purpose: board strapping for the select pins and programming supply
// Assumes: strapCode is {supply high, bit2, bit1, bit0}
// Notes: levels stay fixed unless the bench moves the strap on purpose
`timescale 1ns/1ns
module bma_strap_model (
  input wire logic [3:0] strapCode,
  output logic opSelectBit0,
  output logic opSelectBit1,
  output logic opSelectBit2,
  output logic vppHigh
);
  // straps are static board levels
  assign {vppHigh, opSelectBit2, opSelectBit1, opSelectBit0} = strapCode;
endmodule // bma_strap_model

// file: tb/boot_mode_and_address_map_tb_top.sv
// Purpose: self-checking bench for boot mode decode and address map
// Assumes: zero-wait APB, one-cycle address unit latency
// Notes: every strap code is tried, with fresh reset each time
`timescale 1ns/1ns
module boot_mode_and_address_map_tb_top import bma_pkg::*; ;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] strapCode = 4'h0;
  logic opSelectBit0, opSelectBit1, opSelectBit2, vppHigh;
  bma_apb_req_t apbReq = '0;
  bma_apb_rsp_t apbRsp;
  bma_pinctl_t pinctl;
  logic [15:0] busWidthConfig;
  bma_mode_info_t modeInfo;
  logic modeProhibited, flashProg, calcValid = 1'b0, addrValid, err;
  logic [31:0] pcBase = '0, branchDisp = '0, dataBase = '0, dataDisp = '0, rd, wd;
  logic [31:0] sh [0:5];
  bma_addr_res_t addrRes;
  bma_mode_t m;
  bma_mode_info_t info;
  logic [4:0] c;
  int miscompares = 0, samplesChecked = 0, cycleCount = 0;
  integer seed = 32'h8b74_dfd7;

  always #2 clk_sys = ~clk_sys;

  bma_strap_model strap (.strapCode(strapCode), .opSelectBit0(opSelectBit0),
    .opSelectBit1(opSelectBit1), .opSelectBit2(opSelectBit2), .vppHigh(vppHigh));

  bma_boot_ctrl uut (.clk_sys(clk_sys), .nrst(nrst), .opSelectBit0(opSelectBit0),
    .opSelectBit1(opSelectBit1), .opSelectBit2(opSelectBit2), .vppHigh(vppHigh),
    .apbReq(apbReq), .apbRsp(apbRsp), .pinctl(pinctl), .busWidthConfig(busWidthConfig),
    .modeInfo(modeInfo), .modeProhibited(modeProhibited), .flashProg(flashProg),
    .calcValid(calcValid), .pcBase(pcBase), .branchDisp(branchDisp), .dataBase(dataBase),
    .dataDisp(dataDisp), .addrRes(addrRes), .addrValid(addrValid));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic bma_mode_t modeOf(input logic [3:0] k);
    if (k[3]) return (k[2:1] == 2'b01) ? MODE_FLASH : MODE_PROHIBITED;
    if (k[2]) return MODE_PROHIBITED;
    return bma_mode_t'({1'b0, k[1:0]});
  endfunction

  function automatic bma_mode_info_t infoOf(input bma_mode_t md);
    bma_mode_info_t r;
    r.mode = md;
    r.internalBoot = (md == MODE_SINGLE0) || (md == MODE_FLASH);
    r.romBlocked = (md == MODE_ROMLESS0) || (md == MODE_ROMLESS1);
    r.busWidth16 = (md != MODE_ROMLESS1);
    r.romBase = (md == MODE_SINGLE1) ? 28'h010_0000 : 28'h000_0000;
    return r;
  endfunction

  function automatic bma_addr_res_t addrOf(input bma_mode_t md, input logic [31:0] pb, bd,
      db, dd);
    bma_addr_res_t r;
    logic [27:0] base;
    base = (md == MODE_SINGLE1) ? 28'h010_0000 : 28'h000_0000;
    r.pcTarget = {6'h00, pb[25:0] + bd[25:0]};
    r.dataAddr = db + dd;
    r.physAddr = r.dataAddr[27:0];
    r.romHit = (md inside {MODE_SINGLE0, MODE_SINGLE1, MODE_FLASH}) &&
      r.physAddr >= base && r.physAddr < base + 28'h010_0000;
    r.romBlocked = (md inside {MODE_ROMLESS0, MODE_ROMLESS1}) &&
      (r.physAddr < 28'h010_0000 || r.pcTarget < 32'h0010_0000);
    r.ioFetchFault = r.pcTarget[25:0] >= 26'h3FF_F000;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [127:0] e, input logic [127:0] g);
    samplesChecked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic giveVerdict();
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic apbXfer(input logic wr, input logic [31:0] a, d, output logic [31:0] q,
      output logic e);
    int n;
    @(posedge clk_sys);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'b1);
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    chk("waitStates", 1, n);
  endtask

  task automatic calc(input logic [31:0] pb, bd, db, dd);
    bma_addr_res_t e;
    e = addrOf(m, pb, bd, db, dd);
    @(posedge clk_sys);
    calcValid <= 1'b1;
    {pcBase, branchDisp, dataBase, dataDisp} <= {pb, bd, db, dd};
    @(posedge clk_sys);
    calcValid <= 1'b0;
    #1;
    chk("addrValid", 1, addrValid);
    if (m == MODE_PROHIBITED) chk("addrCore", e[94:3], addrRes[94:3]);
    else chk("addrRes", e, addrRes);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 20000) begin
      miscompares++;
      giveVerdict();
    end
  end

  initial begin
    for (c = 5'd0; c < 5'd16; c++) begin
      @(posedge clk_sys);
      strapCode <= c[3:0];
      nrst <= 1'b0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      #1;
      m = modeOf(c[3:0]);
      info = infoOf(m);
      sh[0] = (m == MODE_SINGLE0) ? 32'h0000_0000 : 32'h0000_00FF;
      sh[1] = (m == MODE_SINGLE0) ? 32'h0000_0000 : 32'h0000_FFFF;
      sh[2] = sh[0];
      sh[3] = (m == MODE_SINGLE0) ? 32'h0000_0000 : 32'h0000_0053;
      sh[4] = (m == MODE_SINGLE0) ? 32'h0000_0000 : 32'h0000_000F;
      sh[5] = (m == MODE_ROMLESS1) ? 32'h0000_0000 : 32'h0000_5555;
      chk("mode", m, modeInfo.mode);
      chk("prohibited", m == MODE_PROHIBITED, modeProhibited);
      chk("flashProg", m == MODE_FLASH, flashProg);
      if (m != MODE_PROHIBITED) chk("modeInfo", info, modeInfo);
      chk("pinctl", {sh[0][7:0], sh[1][15:0], sh[2][7:0], sh[3][7:0],
        sh[4][7:0]}, pinctl);
      chk("busWidth", sh[5][15:0], busWidthConfig);
      @(posedge clk_sys);
      strapCode <= ~c[3:0];
      for (int i = 0; i < 6; i++) begin
        apbXfer(1'b0, 32'(i * 4), 32'h0000_0000, rd, err);
        chk("regReset", sh[i], rd);
      end
      for (int i = 0; i < 6; i++) begin
        wd = $random(seed);
        apbXfer(1'b1, 32'(i * 4), wd, rd, err);
        sh[i] = wd & ((i == 1 || i == 5) ? 32'h0000_FFFF : 32'h0000_00FF);
        apbXfer(1'b0, 32'(i * 4), 32'h0000_0000, rd, err);
        chk("regWrite", sh[i], rd);
      end
      chk("pinctlSet", {sh[0][7:0], sh[1][15:0], sh[2][7:0], sh[3][7:0],
        sh[4][7:0]}, pinctl);
      apbXfer(1'b1, 32'h0000_0018, $random(seed), rd, err);
      apbXfer(1'b0, 32'h0000_0018, 32'h0000_0000, rd, err);
      chk("status", {23'h0, m == MODE_FLASH, m == MODE_PROHIBITED, info.busWidth16,
        info.internalBoot, info.romBlocked, 1'b0, m}, rd);
      apbXfer(1'b0, 32'h0000_001C, 32'h0000_0000, rd, err);
      chk("unmappedErr", 1, err);
      chk("unmappedData", 0, rd);
      chk("modeHeld", m, modeInfo.mode);
      calc(32'h03FF_FFFF, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_0001);
      calc(32'h0000_0000, 32'hFFFF_FFFF, 32'hF010_0000, 32'h0000_0100);
      calc(32'h0000_1000, 32'h0000_0000, 32'h1000_0000, 32'h000F_FFFF);
      repeat (3) calc($random(seed), $random(seed), $random(seed), $random(seed));
    end
    giveVerdict();
  end
endmodule // boot_mode_and_address_map_tb_top
